// ==== include/bridge_term_pkg.sv ====
// constants, types and carriers of the bridge termination handler
package bridge_term_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00; // serr enable, abort mode
  localparam logic [7:0] OFF_SERR_DIS = 8'h04; // per-event serr disables
  localparam logic [7:0] OFF_PSTAT    = 8'h08; // primary status, w1c
  localparam logic [7:0] OFF_SSTAT    = 8'h0c; // secondary status, w1c
  localparam logic [7:0] OFF_STATE    = 8'h10; // slot states, read only
  localparam int CTRL_SERR_EN  = 0;
  localparam int CTRL_MA_MODE  = 1;
  localparam int DIS_DW_LIMIT  = 0;
  localparam int DIS_PW_LIMIT  = 1;
  localparam int DIS_DR_LIMIT  = 2;
  localparam int DIS_PW_MABORT = 3;
  localparam int ST_SIG_TA     = 0;
  localparam int ST_RCV_TA     = 1;
  localparam int ST_RCV_MA     = 2;
  localparam int ST_SIG_SERR   = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] DIS_RESET  = 4'h0;
  localparam logic [3:0] STAT_RESET = 4'h0;

  // ---------------------------------------------------------------
  // bus commands, counts and timing
  // ---------------------------------------------------------------
  localparam logic [3:0]  CMD_MW   = 4'h7;      // memory write
  localparam logic [3:0]  CMD_MWI  = 4'hf;      // write and invalidate
  localparam logic [31:0] ALL_ONES = 32'hffffffff;
  localparam logic [7:0]  PW_MIN_DWORDS = 8'h08; // room needed to post
  localparam int DEVSEL_CLKS       = 5;         // clocks to wait for devsel
  localparam int ATTEMPT_LIMIT_DEF = 2 ** 24;   // attempts before giving up
  localparam int MTO_CYCLES_DEF    = 32768;     // repeat window, clocks
  localparam int NSLOT             = 3;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {KIND_DW, KIND_PW, KIND_DR} xact_kind_t;
  typedef enum logic [1:0] {TERM_NORMAL, TERM_RETRY, TERM_DISC,
                            TERM_TABORT} term_kind_t;
  typedef enum logic [2:0] {RSP_NONE, RSP_DATA, RSP_DATA_DISC, RSP_RETRY,
                            RSP_DISC, RSP_TABORT} resp_kind_t;
  typedef enum logic [2:0] {SL_IDLE, SL_ISSUE, SL_BUSY, SL_HELD,
                            SL_ABORT} slot_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;    // initiator attempt this cycle
    xact_kind_t  kind;
    logic        dir;      // 1: initiator sits on the secondary bus
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] wdata;
    logic        multi;    // more than one data phase asked for
    logic        prefetch;
    logic        locked;
    logic [7:0]  want;     // dwords the initiator asks for
  } init_req_t;

  typedef struct packed {
    logic        dq_full;   // delayed queue cannot take more
    logic        lock_active;
    logic        at_head;   // completion at head of return queue
    logic        pw_ahead;  // posted write precedes read data
    logic        discarding;// prefetched data being thrown away
    logic [7:0]  pw_free;   // free posted buffer dwords
    logic        boundary;  // internal address boundary reached
    logic        no_space;  // write buffer full
    logic        no_read;   // no more read data to hand out
  } q_stat_t;

  typedef struct packed {
    logic        valid;
    xact_kind_t  kind;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] wdata;
  } issue_t;

  typedef struct packed {
    logic        valid;     // target-bus transaction ended
    term_kind_t  kind;
    logic [7:0]  dwords;    // dwords moved before the end
    logic        left;      // posted data still buffered
    logic [31:0] rdata;
  } tgt_term_t;

endpackage

// ==== rtl/bridge_term.sv ====
// termination handler of a two-bus bridge with an ahb-lite register slave
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
module bridge_term #(
  parameter int unsigned ATTEMPT_LIMIT = bridge_term_pkg::ATTEMPT_LIMIT_DEF,
  parameter int unsigned MTO_CYCLES    = bridge_term_pkg::MTO_CYCLES_DEF
) (
  input  wire logic                       clk,        // 100 mhz clock
  input  wire logic                       resetn,     // async reset
  input  wire logic                       hsel,       // slave select
  input  wire logic [31:0]                haddr,      // byte address
  input  wire logic [1:0]                 htrans,     // transfer type
  input  wire logic                       hwrite,     // write access
  input  wire logic [2:0]                 hsize,      // word only
  input  wire logic [31:0]                hwdata,     // write data
  input  wire logic                       hready,     // bus ready
  output logic      [31:0]                hrdata,     // read data
  output logic                            hreadyout,  // always ready
  output logic                            hresp,      // always okay
  input  wire bridge_term_pkg::init_req_t ireq,       // initiator attempt
  input  wire bridge_term_pkg::q_stat_t   qstat,      // queue conditions
  output bridge_term_pkg::resp_kind_t     iresp,      // initiator answer
  output logic      [31:0]                ird,        // read data
  output bridge_term_pkg::issue_t         iss,        // target-bus request
  input  wire logic                       iss_ready,  // master engine free
  input  wire logic                       frame_start,// frame asserted
  input  wire logic                       devsel,     // devsel seen
  input  wire bridge_term_pkg::tgt_term_t tterm,      // target-bus ending
  output logic                            mst_abort,  // stop, master abort
  output logic                            sys_err     // serr pulse
);
  import bridge_term_pkg::*;

  localparam logic [24:0] LIM     = 25'(ATTEMPT_LIMIT);
  localparam logic [23:0] MTO_END = 24'(MTO_CYCLES - 1);
  localparam logic [2:0]  DS_LAST = 3'(DEVSEL_CLKS - 1);

  slot_state_t st     [NSLOT];
  logic        sdir   [NSLOT];
  logic [31:0] saddr  [NSLOT];
  logic [3:0]  scmd   [NSLOT];
  logic [31:0] swdata [NSLOT];
  logic        smulti [NSLOT];
  logic        spref  [NSLOT];
  logic [23:0] attempts [NSLOT];
  logic [23:0] tmo    [NSLOT];
  logic [7:0]  fetched;
  logic        busy;
  xact_kind_t  cur, sel;
  logic        sel_ok, grant;
  logic        running;
  logic [2:0]  dcnt;
  logic        tev, ev_ma, retry_ev, inc, limit_hit, tab_ev, tbus;
  logic        load, deliver, match, serr_set;
  logic [1:0]  ctrl;
  logic [3:0]  dis;
  logic [3:0]  stat [2];
  logic        wr_pend;
  logic [7:0]  wr_addr;
  xact_kind_t  k;

  // ---------------------------------------------------------------
  // target-bus issue: posted first, then reads, then writes
  // ---------------------------------------------------------------
  always_comb begin
    sel_ok = 1'b1;
    if (st[KIND_PW] == SL_ISSUE) begin
      sel = KIND_PW;
    end else if (st[KIND_DR] == SL_ISSUE) begin
      sel = KIND_DR;
    end else begin
      sel = KIND_DW;
      sel_ok = (st[KIND_DW] == SL_ISSUE);
    end
  end

  assign iss.valid = !busy && sel_ok;
  assign iss.kind  = sel;
  assign iss.addr  = saddr[sel];
  assign iss.cmd   = scmd[sel];
  assign iss.wdata = swdata[sel];
  assign grant     = iss.valid && iss_ready;

  // current target-bus owner
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cur  <= KIND_DW;
    end else if (grant) begin
      busy <= 1'b1;
      cur  <= sel;
    end else if (tev || ev_ma) begin
      busy <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // devsel watch after frame
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
      dcnt    <= 3'h0;
    end else if (frame_start) begin
      running <= 1'b1;
      dcnt    <= 3'h0;
    end else if (running) begin
      running <= !devsel && !mst_abort;
      dcnt    <= dcnt + 3'h1;
    end
  end

  assign mst_abort = running && !devsel && dcnt == DS_LAST;

  // ---------------------------------------------------------------
  // target-bus ending events
  // ---------------------------------------------------------------
  assign tev      = tterm.valid && busy;
  assign ev_ma    = mst_abort && busy;
  assign retry_ev = tev && tterm.kind == TERM_RETRY;
  assign tab_ev   = tev && tterm.kind == TERM_TABORT;
  assign inc      = retry_ev || (tev && cur == KIND_PW && tterm.left &&
                    tterm.kind == TERM_DISC);
  assign limit_hit = inc && ({1'b0, attempts[cur]} + 25'h1 == LIM);
  assign tbus     = !sdir[cur];

  // ---------------------------------------------------------------
  // answer to the initiator
  // ---------------------------------------------------------------
  assign k     = ireq.kind;
  assign match = ireq.addr == saddr[k] && ireq.cmd == scmd[k] &&
                 (k == KIND_DR || ireq.wdata == swdata[k]);

  always_comb begin
    iresp   = RSP_NONE;
    load    = 1'b0;
    deliver = 1'b0;
    if (ireq.valid) begin
      if (qstat.lock_active && !ireq.locked) begin
        iresp = RSP_RETRY;
      end else if (k == KIND_PW) begin
        if (qstat.pw_free < PW_MIN_DWORDS || st[KIND_PW] != SL_IDLE) begin
          iresp = RSP_RETRY;
        end else begin
          load  = 1'b1;
          iresp = (qstat.boundary || qstat.no_space) ? RSP_DATA_DISC
                                                     : RSP_DATA;
        end
      end else if (st[k] == SL_IDLE) begin
        iresp = RSP_RETRY;
        load  = !qstat.dq_full;
      end else if (!match) begin
        iresp = RSP_RETRY;
      end else if (st[k] == SL_ABORT) begin
        iresp   = RSP_TABORT;
        deliver = 1'b1;
      end else if (st[k] != SL_HELD || !qstat.at_head ||
                   (k == KIND_DR && (qstat.pw_ahead || qstat.discarding)))
      begin
        iresp = RSP_RETRY;
      end else if (k == KIND_DW) begin
        deliver = 1'b1;
        iresp = (smulti[k] || qstat.boundary || qstat.no_space)
                ? RSP_DATA_DISC : RSP_DATA;
      end else begin
        deliver = 1'b1;
        iresp = (!spref[k] || ireq.want > fetched || qstat.no_read ||
                 qstat.boundary) ? RSP_DATA_DISC
                                 : RSP_DATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // slot state, address, command and counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NSLOT; i++) begin
        st[i]       <= SL_IDLE;
        sdir[i]     <= 1'b0;
        saddr[i]    <= 32'h0;
        scmd[i]     <= 4'h0;
        swdata[i]   <= 32'h0;
        smulti[i]   <= 1'b0;
        spref[i]    <= 1'b0;
        attempts[i] <= 24'h0;
        tmo[i]      <= 24'h0;
      end
    end else begin
      for (int i = 0; i < NSLOT; i++) begin
        if (load && k == 2'(i)) begin
          st[i]       <= SL_ISSUE;
          sdir[i]     <= ireq.dir;
          saddr[i]    <= ireq.addr;
          scmd[i]     <= ireq.cmd;
          swdata[i]   <= ireq.wdata;
          smulti[i]   <= ireq.multi;
          spref[i]    <= ireq.prefetch;
          attempts[i] <= 24'h0;
          tmo[i]      <= 24'h0;
        end else if (deliver && k == 2'(i)) begin
          st[i] <= SL_IDLE;
        end else if (grant && sel == 2'(i)) begin
          st[i] <= SL_BUSY;
        end else if ((tev || ev_ma) && cur == 2'(i)) begin
          tmo[i] <= 24'h0;
          if (ev_ma) begin
            if (i == int'(KIND_PW)) begin
              st[i] <= SL_IDLE;
            end else begin
              st[i] <= ctrl[CTRL_MA_MODE] ? SL_ABORT : SL_HELD;
            end
          end else if (limit_hit) begin
            st[i] <= (i == int'(KIND_PW)) ? SL_IDLE
                                          : SL_ABORT;
          end else if (tterm.kind == TERM_RETRY) begin
            st[i]       <= SL_ISSUE;
            attempts[i] <= attempts[i] + 24'h1;
          end else if (tterm.kind == TERM_TABORT) begin
            st[i] <= (i == int'(KIND_PW)) ? SL_IDLE
                                          : SL_ABORT;
          end else if (i == int'(KIND_PW)) begin
            if (tterm.kind == TERM_DISC && tterm.left) begin
              st[i]       <= SL_ISSUE;
              saddr[i]    <= saddr[i] + {22'h0, tterm.dwords, 2'b00};
              attempts[i] <= attempts[i] + 24'h1;
              if (scmd[i] == CMD_MWI) begin
                scmd[i] <= CMD_MW;
              end
            end else begin
              st[i] <= SL_IDLE;
            end
          end else begin
            st[i] <= SL_HELD;
          end
        end else if (st[i] == SL_HELD || st[i] == SL_ABORT) begin
          if (tmo[i] == MTO_END) begin
            st[i] <= SL_IDLE;
          end else begin
            tmo[i] <= tmo[i] + 24'h1;
          end
        end
      end
    end
  end

  // read completion data, all ones on a master abort
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ird     <= 32'h0;
      fetched <= 8'h0;
    end else if (ev_ma && cur == KIND_DR) begin
      ird     <= ALL_ONES;
      fetched <= 8'h1;
    end else if (tev && cur == KIND_DR && tterm.kind != TERM_RETRY) begin
      ird     <= tterm.rdata;
      fetched <= tterm.dwords;
    end
  end

  // ---------------------------------------------------------------
  // system error and status flags
  // ---------------------------------------------------------------
  always_comb begin
    serr_set = 1'b0;
    if (ctrl[CTRL_SERR_EN]) begin
      serr_set = (limit_hit && cur == KIND_DW && !dis[DIS_DW_LIMIT]) ||
                 (limit_hit && cur == KIND_PW && !dis[DIS_PW_LIMIT]) ||
                 (limit_hit && cur == KIND_DR && !dis[DIS_DR_LIMIT]) ||
                 (tab_ev && cur == KIND_PW) ||
                 (ev_ma && cur == KIND_PW && ctrl[CTRL_MA_MODE] &&
                  !dis[DIS_PW_MABORT]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_err <= 1'b0;
    end else begin
      sys_err <= serr_set;
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat[0] <= STAT_RESET;
      stat[1] <= STAT_RESET;
    end else begin
      for (int b = 0; b < 2; b++) begin
        for (int f = 0; f < 4; f++) begin
          if (wr_pend && ((b == 0 && wr_addr == OFF_PSTAT) ||
                          (b == 1 && wr_addr == OFF_SSTAT)) && hwdata[f]) begin
            stat[b][f] <= 1'b0;
          end
        end
        if (iresp == RSP_TABORT && ireq.dir == b[0]) begin
          stat[b][ST_SIG_TA] <= 1'b1;
        end
        if (tab_ev && tbus == b[0]) begin
          stat[b][ST_RCV_TA] <= 1'b1;
        end
        if (ev_ma && tbus == b[0]) begin
          stat[b][ST_RCV_MA] <= 1'b1;
        end
      end
      if (serr_set) begin
        stat[0][ST_SIG_SERR] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      hrdata  <= 32'h0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          OFF_CTRL:     hrdata <= {30'h0, ctrl};
          OFF_SERR_DIS: hrdata <= {28'h0, dis};
          OFF_PSTAT:    hrdata <= {28'h0, stat[0]};
          OFF_SSTAT:    hrdata <= {28'h0, stat[1]};
          OFF_STATE:    hrdata <= {22'h0, busy, st[KIND_DR], st[KIND_PW],
                                   st[KIND_DW]};
          default:      hrdata <= 32'h0;
        endcase
      end
    end
  end

  // control registers written in the data phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      dis  <= DIS_RESET;
    end else if (wr_pend && wr_addr == OFF_CTRL) begin
      ctrl <= hwdata[1:0];
    end else if (wr_pend && wr_addr == OFF_SERR_DIS) begin
      dis <= hwdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence no_devsel_s;
    frame_start ##1 !devsel [*5];
  endsequence

  devsel_watch_a: assert property (no_devsel_s |-> mst_abort)
    else $error("no master abort after five clocks without devsel");
  rcv_mabort_a: assert property (ev_ma |=>
                                 stat[$past(tbus)][ST_RCV_MA])
    else $error("received master abort flag not set");
  lock_retry_a: assert property (ireq.valid && qstat.lock_active &&
                                 !ireq.locked |-> iresp == RSP_RETRY)
    else $error("unlocked attempt during lock not retried");
  pw_space_a: assert property (ireq.valid && ireq.kind == KIND_PW &&
                               qstat.pw_free < PW_MIN_DWORDS |->
                               iresp == RSP_RETRY)
    else $error("posted write accepted without room");
  pw_same_addr_a: assert property (retry_ev && cur == KIND_PW &&
                                   !limit_hit |=> st[KIND_PW] == SL_ISSUE &&
                                   saddr[KIND_PW] == $past(saddr[KIND_PW]))
    else $error("posted retry changed address");
  pw_next_addr_a: assert property (tev && cur == KIND_PW && !limit_hit &&
                                   tterm.kind == TERM_DISC && tterm.left |=>
                                   saddr[KIND_PW] == $past(saddr[KIND_PW]) +
                                   {22'h0, $past(tterm.dwords), 2'b00})
    else $error("posted restart not at next dword");
  mwi_to_mw_a: assert property (tev && cur == KIND_PW && tterm.left &&
                                tterm.kind == TERM_DISC && !limit_hit &&
                                scmd[KIND_PW] == CMD_MWI |=>
                                scmd[KIND_PW] == CMD_MW)
    else $error("remaining data not sent as plain write");
  dw_limit_a: assert property (limit_hit && cur == KIND_DW &&
                               ctrl[CTRL_SERR_EN] && !dis[DIS_DW_LIMIT] |=>
                               sys_err && st[KIND_DW] == SL_ABORT)
    else $error("write limit without abort state or serr");
  sig_tabort_a: assert property (iresp == RSP_TABORT && !ireq.dir |=>
                                 stat[0][ST_SIG_TA])
    else $error("signaled target abort flag not set");
  dr_tabort_a: assert property (tab_ev && cur == KIND_DR |=>
                                st[KIND_DR] == SL_ABORT &&
                                stat[$past(tbus)][ST_RCV_TA])
    else $error("read target abort not recorded");
  dw_single_a: assert property (deliver && k == KIND_DW && !smulti[k] &&
                                st[KIND_DW] == SL_HELD &&
                                !qstat.boundary && !qstat.no_space |->
                                iresp == RSP_DATA)
    else $error("single phase write disconnected");
  attempt_clear_a: assert property (load && k == KIND_DR |=>
                                    attempts[KIND_DR] == 24'h0)
    else $error("attempt counter not cleared at queueing");

endmodule

// ==== testbench/tgt_model.sv ====
// target-bus partner: answers issued requests with a chosen termination
module tgt_model
  import bridge_term_pkg::*;
(
  input  wire logic       clk,         // bus clock
  input  wire logic       resetn,      // async reset
  input  wire issue_t     iss,         // request from the bridge
  input  wire term_kind_t tkind,       // termination to return
  input  wire logic       mute,        // 1: no target claims the cycle
  output logic            iss_ready,   // free to start a frame
  output logic            frame_start, // frame pulse
  output logic            devsel,      // device select level
  output tgt_term_t       tterm        // end of transaction
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  assign iss_ready = (cnt == 4'h0);
  // frame sequencer; a muted target lets the bridge run into its timeout
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      cnt <= 4'h0;
    else if (cnt == 4'h0)
      cnt <= {3'h0, iss.valid};
    else
      cnt <= (cnt < 4'h9) ? cnt + 4'h1 : 4'h0;
  end
  assign frame_start  = (cnt == 4'h1);
  assign devsel       = !mute && cnt >= 4'h2;
  // read data follows the frame count, changing every cycle while a frame runs
  assign tterm.valid  = !mute && cnt == 4'h3;
  assign tterm.kind   = tkind;
  assign tterm.dwords = 8'h01;
  assign tterm.left   = (tkind == TERM_DISC); // disconnect leaves data
  assign tterm.rdata  = {8{cnt}};
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench of the termination handler
module tb_top;
  import bridge_term_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, iss_ready, fs, dv;
  logic mute, mst_abort, sys_err;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, ird, rd;
  init_req_t ireq;
  q_stat_t qs;
  resp_kind_t iresp;
  issue_t iss;
  tgt_term_t tterm;
  term_kind_t tk;
  int error_cnt = 0;
  int comparisons = 0;
  bridge_term #(.ATTEMPT_LIMIT(4), .MTO_CYCLES(40)) uut (.clk(clk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ireq(ireq),
    .qstat(qs), .iresp(iresp), .ird(ird), .iss(iss), .iss_ready(iss_ready),
    .frame_start(fs), .devsel(dv), .tterm(tterm), .mst_abort(mst_abort),
    .sys_err(sys_err));
  tgt_model tgt (.clk(clk), .resetn(resetn), .iss(iss), .tkind(tk),
    .mute(mute), .iss_ready(iss_ready), .frame_start(fs), .devsel(dv),
    .tterm(tterm));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bounded wait for a condition sampled at rising edges
  task automatic wait_for(input bit done_on_end);
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (done_on_end ? (tterm.valid || mst_abort) : hreadyout === 1'b1)
        return;
    end
    error_cnt++;
    end_sim();
  endtask
  // one single ahb-lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
    wait_for(0);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_for(0);
    rd = hrdata;
  endtask
  // one initiator attempt; the answer is combinational in the same cycle
  task automatic att(input xact_kind_t k, input resp_kind_t e,
                     input logic [3:0] c = CMD_MW, input logic m = 1'b1);
    init_req_t r;
    r = '0;
    r.valid = 1'b1; r.kind = k; r.addr = 32'h100; r.cmd = c;
    r.multi = m; r.want = 8'h01;
    @(posedge clk);
    ireq <= r;
    #1 chk("iresp", {29'h0, e}, {29'h0, iresp});
    @(posedge clk);
    ireq <= '0;
  endtask
  initial begin
    resetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0;
    hwdata = '0; ireq = '0; qs = '0; qs.pw_free = 8'h08; tk = TERM_NORMAL;
    mute = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    ahb(0, OFF_CTRL, 0); chk("ctrl", {30'h0, CTRL_RESET}, rd);
    ahb(0, 8'h20, 0); chk("unmapped", 0, rd);
    ahb(1, OFF_CTRL, 1);
    att(KIND_DW, RSP_RETRY); wait_for(1);
    qs.at_head <= 1'b1;
    att(KIND_DW, RSP_DATA_DISC);
    tk <= TERM_TABORT;
    att(KIND_DW, RSP_RETRY); wait_for(1);
    att(KIND_DW, RSP_TABORT);
    ahb(0, OFF_PSTAT, 0); chk("pstat", 32'h1, rd);
    ahb(0, OFF_SSTAT, 0); chk("sstat", 32'h2, rd);
    qs.pw_free <= 8'h07;
    att(KIND_PW, RSP_RETRY);
    qs.lock_active <= 1'b1;
    att(KIND_DR, RSP_RETRY);
    qs.lock_active <= 1'b0; mute <= 1'b1; tk <= TERM_NORMAL;
    att(KIND_DR, RSP_RETRY); wait_for(1);
    chk("mst_abort", 1, {31'h0, mst_abort});
    mute <= 1'b0;
    att(KIND_DR, RSP_DATA_DISC);
    chk("ird", ALL_ONES, ird);
    ahb(0, OFF_SSTAT, 0); chk("sstat", 32'h6, rd);
    att(KIND_DW, RSP_RETRY, CMD_MW, 1'b0); wait_for(1);
    att(KIND_DW, RSP_DATA, CMD_MW, 1'b0);
    tk <= TERM_RETRY;
    att(KIND_DW, RSP_RETRY); wait_for(1);
    att(KIND_DW, RSP_RETRY); repeat (3) wait_for(1);
    #1 chk("sys_err", 1, {31'h0, sys_err});
    att(KIND_DW, RSP_TABORT);
    tk <= TERM_TABORT;
    att(KIND_DR, RSP_RETRY); wait_for(1);
    att(KIND_DR, RSP_TABORT);
    qs.pw_free <= 8'h08; tk <= TERM_DISC;
    att(KIND_PW, RSP_DATA, CMD_MWI); wait_for(1);
    tk <= TERM_RETRY;
    #1 chk("iss.addr", 32'h104, iss.addr);
    chk("iss.cmd", {28'h0, CMD_MW}, {28'h0, iss.cmd});
    wait_for(1);
    #1 chk("iss.addr", 32'h104, iss.addr);
    repeat (2) wait_for(1);
    #1 chk("sys_err", 1, {31'h0, sys_err});
    ahb(0, OFF_STATE, 0); chk("state", 0, rd);
    tk <= TERM_TABORT;
    att(KIND_PW, RSP_DATA); wait_for(1);
    #1 chk("sys_err", 1, {31'h0, sys_err});
    ahb(0, OFF_PSTAT, 0); chk("pstat", 32'h9, rd);
    end_sim();
  end
endmodule
